// >>> design/rxmap_top.v
// per-port virtual channel / data type mapping and frame line counter
// assumes register strobes from an i2c target on the same clock;
// packet header inputs from the link receiver are same-clock logic
`timescale 1ns/10ps
`default_nettype none
`include "rxmap_defs.vh"
module rxmap_top (
    input  wire       CLK_I,
    input  wire       RESETN_I,
    input  wire [1:0] PORT_SEL_I,
    input  wire       REG_WR_I,
    input  wire       REG_RD_I,
    input  wire [7:0] REG_ADDR_I,
    input  wire [7:0] REG_WDATA_I,
    output reg  [7:0] REG_RDATA_O,
    input  wire [3:0] LINES_CHANGED_IRQ_ENABLE_I,
    input  wire [7:0] PORT_INPUT_MODE_I,
    input  wire [3:0] FRAME_START_I,
    input  wire [3:0] LINE_END_I,
    input  wire [3:0] FRAME_END_I,
    input  wire       PKT_VALID_I,
    output wire       PKT_READY_O,
    input  wire [1:0] PKT_PORT_I,
    input  wire [1:0] PKT_CHANNEL_I,
    input  wire [5:0] PKT_TYPE_I,
    output reg        OUT_VALID_O,
    input  wire       OUT_READY_I,
    output reg  [1:0] OUT_PORT_O,
    output reg  [1:0] OUT_CHANNEL_O,
    output reg  [5:0] OUT_TYPE_O
);
    // ****************************************************************
    // strap capture
    // ****************************************************************
    reg  [7:0] strap_meta;
    reg  [7:0] strap_sync;
    reg  [1:0] strap_age;
    reg  [7:0] port_input_mode;

    always @(posedge CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            strap_meta      <= 8'h00;
            strap_sync      <= 8'h00;
            strap_age       <= 2'h0;
            port_input_mode <= 8'h00;
        end else begin
            strap_meta <= PORT_INPUT_MODE_I;
            strap_sync <= strap_meta;
            if (strap_age != `RXMAP_STRAP_SETTLED) begin
                strap_age <= strap_age + 2'h1;
            end
            if (strap_age == `RXMAP_STRAP_CAPTURE) begin
                port_input_mode <= strap_sync; // RULE_13
            end
        end
    end

    // ****************************************************************
    // per-port registers and line counters
    // ****************************************************************
    wire [7:0]  raw10_reg   [0:3];
    wire [7:0]  raw12_reg   [0:3];
    wire [7:0]  remap_reg   [0:3];
    wire [15:0] lines_rep   [0:3];
    wire [7:0]  lo_latched  [0:3];
    wire        hi_read     = REG_RD_I && (REG_ADDR_I == `RXMAP_ADDR_LINES_HI);
    wire        lo_read     = REG_RD_I && (REG_ADDR_I == `RXMAP_ADDR_LINES_LO);

    genvar g;
    generate
        for (g = 0; g < `RXMAP_PORTS; g = g + 1) begin : g_port
            reg  [7:0]  raw10_channel_type;
            reg  [7:0]  raw12_channel_type;
            reg  [7:0]  csi_channel_remap;
            reg  [15:0] line_count;
            reg  [15:0] frame_lines;
            reg  [7:0]  frame_lines_low;
            reg         frozen;
            wire        sel = (PORT_SEL_I == g[1:0]);
            wire        wr  = REG_WR_I && sel; // RULE_01

            assign raw10_reg[g]  = raw10_channel_type;
            assign raw12_reg[g]  = raw12_channel_type;
            assign remap_reg[g]  = csi_channel_remap;
            assign lines_rep[g]  = frame_lines;
            assign lo_latched[g] = frame_lines_low;

            always @(posedge CLK_I or negedge RESETN_I) begin
                if (!RESETN_I) begin
                    raw10_channel_type <= {g[1:0], `RXMAP_RAW10_TYPE_RST}; // RULE_02 RULE_03
                    raw12_channel_type <= {g[1:0], `RXMAP_RAW12_TYPE_RST}; // RULE_05 RULE_06
                    csi_channel_remap  <= `RXMAP_REMAP_RST;
                    line_count         <= 16'h0000;
                    frame_lines        <= 16'h0000;
                    frame_lines_low    <= 8'h00;
                    frozen             <= 1'b0;
                end else begin
                    if (wr && REG_ADDR_I == `RXMAP_ADDR_RAW10) begin
                        raw10_channel_type <= REG_WDATA_I;
                    end
                    if (wr && REG_ADDR_I == `RXMAP_ADDR_RAW12) begin
                        raw12_channel_type <= REG_WDATA_I;
                    end
                    if (wr && REG_ADDR_I == `RXMAP_ADDR_REMAP) begin
                        csi_channel_remap <= REG_WDATA_I;
                    end
                    // count lines inside the frame
                    if (FRAME_START_I[g]) begin
                        line_count <= 16'h0000;
                    end else if (LINE_END_I[g]) begin
                        line_count <= line_count + 16'h0001; // RULE_14
                    end
                    // capture at frame end unless frozen awaiting a read
                    if (FRAME_END_I[g] && !frozen) begin
                        frame_lines <= line_count + {15'h0000, LINE_END_I[g]}; // RULE_14
                        if (LINES_CHANGED_IRQ_ENABLE_I[g]) begin
                            frozen <= 1'b1; // RULE_11
                        end
                    end else if (sel && (hi_read || lo_read)) begin
                        frozen <= 1'b0; // RULE_11
                    end else if (!LINES_CHANGED_IRQ_ENABLE_I[g]) begin
                        frozen <= 1'b0;
                    end
                    if (sel && hi_read) begin
                        frame_lines_low <= frame_lines[7:0]; // RULE_12
                    end
                end
            end
        end
    endgenerate

    // ****************************************************************
    // register read
    // ****************************************************************
    reg [7:0] next_rdata;
    always @* begin
        next_rdata = 8'h00;
        case (REG_ADDR_I)
            `RXMAP_ADDR_RAW10:    next_rdata = raw10_reg[PORT_SEL_I];
            `RXMAP_ADDR_RAW12:    next_rdata = raw12_reg[PORT_SEL_I];
            `RXMAP_ADDR_REMAP:    next_rdata = remap_reg[PORT_SEL_I];
            `RXMAP_ADDR_LINES_HI: next_rdata = lines_rep[PORT_SEL_I][15:8]; // RULE_10
            `RXMAP_ADDR_LINES_LO: next_rdata = lo_latched[PORT_SEL_I]; // RULE_10 RULE_12
            default:              next_rdata = 8'h00;
        endcase
    end

    always @(posedge CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            REG_RDATA_O <= 8'h00;
        end else if (REG_RD_I) begin
            REG_RDATA_O <= next_rdata;
        end
    end

    // ****************************************************************
    // header buffer and channel / type mapping
    // ****************************************************************
    wire                     fifo_valid;
    wire [`RXMAP_PKT_W-1:0]  fifo_data;
    wire                     take = fifo_valid && (!OUT_VALID_O || OUT_READY_I);

    rxmap_fifo #(
        .WIDTH (`RXMAP_PKT_W),
        .DEPTH (`RXMAP_FIFO_DEPTH),
        .AW    (`RXMAP_FIFO_AW)
    ) u_fifo (
        .clk_i       (CLK_I),
        .resetn_i    (RESETN_I),
        .in_valid_i  (PKT_VALID_I),
        .in_ready_o  (PKT_READY_O),
        .in_data_i   ({PKT_PORT_I, PKT_CHANNEL_I, PKT_TYPE_I}),
        .out_valid_o (fifo_valid),
        .out_ready_i (take),
        .out_data_o  (fifo_data)
    );

    wire [1:0] f_port = fifo_data[9:8];
    wire [1:0] f_ch   = fifo_data[7:6];
    wire [5:0] f_type = fifo_data[5:0];
    reg  [1:0] f_mode;
    reg  [7:0] f_remap;
    reg  [1:0] next_channel;
    reg  [5:0] next_type;

    always @* begin
        f_mode       = port_input_mode[2*f_port +: 2];
        f_remap      = remap_reg[f_port];
        next_channel = f_ch;
        next_type    = f_type;
        case (f_mode)
            `RXMAP_MODE_CSI: begin
                next_channel = f_remap[2*f_ch +: 2]; // RULE_08 RULE_09
            end
            `RXMAP_MODE_RAW12_LF, `RXMAP_MODE_RAW12_HF: begin
                next_channel = raw12_reg[f_port][`RXMAP_CH_MSB:`RXMAP_CH_LSB]; // RULE_07
                next_type    = raw12_reg[f_port][`RXMAP_TYPE_MSB:0]; // RULE_07
            end
            `RXMAP_MODE_RAW10: begin
                next_channel = raw10_reg[f_port][`RXMAP_CH_MSB:`RXMAP_CH_LSB]; // RULE_04
                next_type    = raw10_reg[f_port][`RXMAP_TYPE_MSB:0]; // RULE_04
            end
            default: begin
                next_channel = f_ch;
            end
        endcase
    end

    always @(posedge CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            OUT_VALID_O   <= 1'b0;
            OUT_PORT_O    <= 2'h0;
            OUT_CHANNEL_O <= 2'h0;
            OUT_TYPE_O    <= 6'h00;
        end else if (take) begin
            OUT_VALID_O   <= 1'b1;
            OUT_PORT_O    <= f_port;
            OUT_CHANNEL_O <= next_channel;
            OUT_TYPE_O    <= next_type;
        end else if (OUT_READY_I) begin
            OUT_VALID_O <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// >>> shared/rxmap_defs.vh
// constants for the per-port channel map and frame line count block
// assumes a byte-wide register port driven by an i2c target decoder
// Operation
// RULE_01: one register copy per port, selected port
// RULE_02: raw10 channel field bits 7:6, port default
// RULE_03: raw10 type field bits 5:0, default 0x2B
// RULE_04: raw10 settings used only in raw10 mode
// RULE_05: raw12 channel field bits 7:6, port default
// RULE_06: raw12 type field bits 5:0, default 0x2C
// RULE_07: raw12 settings used only in raw12 modes
// RULE_08: csi mode remaps channel through 2-bit map fields
// RULE_09: remap only in csi mode, raw otherwise
// RULE_10: sixteen bit line count as two bytes
// RULE_11: irq enable freezes count until read
// RULE_12: high byte read latches low byte copy
// RULE_13: mode strap 00 csi 01/10 raw12 11 raw10
// RULE_14: lines counted per frame, captured at frame end
`ifndef RXMAP_DEFS_VH
`define RXMAP_DEFS_VH
`define RXMAP_PORTS          4
`define RXMAP_ADDR_RAW10     8'h70
`define RXMAP_ADDR_RAW12     8'h71
`define RXMAP_ADDR_REMAP     8'h72
`define RXMAP_ADDR_LINES_HI  8'h73
`define RXMAP_ADDR_LINES_LO  8'h74
`define RXMAP_RAW10_TYPE_RST 6'h2B
`define RXMAP_RAW12_TYPE_RST 6'h2C
`define RXMAP_REMAP_RST      8'hE4
`define RXMAP_MODE_CSI       2'h0
`define RXMAP_MODE_RAW12_LF  2'h1
`define RXMAP_MODE_RAW12_HF  2'h2
`define RXMAP_MODE_RAW10     2'h3
`define RXMAP_CH_MSB         7
`define RXMAP_CH_LSB         6
`define RXMAP_TYPE_MSB       5
`define RXMAP_FIFO_DEPTH     8
`define RXMAP_FIFO_AW        3
`define RXMAP_PKT_W          10
`define RXMAP_STRAP_CAPTURE  2'h2
`define RXMAP_STRAP_SETTLED  2'h3
`endif

// >>> design/rxmap_fifo.v
// small synchronous fifo with valid/ready on both sides
// assumes a single clock and active-low asynchronous reset
`timescale 1ns/10ps
`default_nettype none
module rxmap_fifo #(
    parameter WIDTH = 10,
    parameter DEPTH = 8,
    parameter AW    = 3
) (
    input  wire             clk_i,
    input  wire             resetn_i,
    input  wire             in_valid_i,
    output wire             in_ready_o,
    input  wire [WIDTH-1:0] in_data_i,
    output wire             out_valid_o,
    input  wire             out_ready_i,
    output wire [WIDTH-1:0] out_data_o
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0]    wr_ptr;
    reg [AW-1:0]    rd_ptr;
    reg [AW:0]      used;
    reg [AW:0]      next_used;
    reg             room;
    wire            push;
    wire            pop;

    // ready comes from a flop so the top output is registered
    assign in_ready_o  = room;
    assign out_valid_o = (used != {(AW+1){1'b0}});
    assign out_data_o  = mem[rd_ptr];
    assign push        = in_valid_i & room;
    assign pop         = out_valid_o & out_ready_i;

    always @* begin
        next_used = used;
        if (push && !pop) begin
            next_used = used + {{AW{1'b0}}, 1'b1};
        end else if (pop && !push) begin
            next_used = used - {{AW{1'b0}}, 1'b1};
        end
    end

    always @(posedge clk_i) begin
        if (push) begin
            mem[wr_ptr] <= in_data_i;
        end
    end

    always @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            wr_ptr <= {AW{1'b0}};
            rd_ptr <= {AW{1'b0}};
            used   <= {(AW+1){1'b0}};
            room   <= 1'b1;
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + {{(AW-1){1'b0}}, 1'b1};
            end
            if (pop) begin
                rd_ptr <= rd_ptr + {{(AW-1){1'b0}}, 1'b1};
            end
            used <= next_used;
            room <= (next_used != DEPTH[AW:0]);
        end
    end
endmodule
`default_nettype wire

// >>> sim/rxmap_sink.sv
// downstream header sink model
// assumes the bench drives stall_i from its random source
`timescale 1ns/10ps
`default_nettype none
module rxmap_sink (
    input  wire logic clk_i,
    input  wire logic resetn_i,
    input  wire logic stall_i,
    output var  logic ready_o
);
    always @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) ready_o <= 1'b0;
        else ready_o <= !stall_i;
    end
endmodule
`default_nettype wire

// >>> sim/rxmap_sva.sv
// port checks for the channel map block
// assumes one clock and an active-low reset, bound onto rxmap_top
`timescale 1ns/10ps
`default_nettype none
module rxmap_sva (
    input wire logic       CLK_I,
    input wire logic       RESETN_I,
    input wire logic [1:0] PORT_SEL_I,
    input wire logic       REG_WR_I,
    input wire logic       REG_RD_I,
    input wire logic [7:0] REG_ADDR_I,
    input wire logic [7:0] REG_WDATA_I,
    input wire logic [7:0] REG_RDATA_O,
    input wire logic       PKT_VALID_I,
    input wire logic       PKT_READY_O,
    input wire logic       OUT_VALID_O,
    input wire logic       OUT_READY_I,
    input wire logic [1:0] OUT_PORT_O,
    input wire logic [1:0] OUT_CHANNEL_O,
    input wire logic [5:0] OUT_TYPE_O
);
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RESETN_I);
    property p_wr_rd;
        REG_WR_I && REG_ADDR_I inside {8'h70, 8'h71, 8'h72} ##1 REG_RD_I
        && $stable(REG_ADDR_I) && $stable(PORT_SEL_I) |=> REG_RDATA_O == $past(REG_WDATA_I, 2);
    endproperty
    a_wr_rd: assert property (p_wr_rd) else $error("read back differs");
    property p_unmap;
        REG_RD_I && !(REG_ADDR_I inside {[8'h70:8'h74]}) |=> REG_RDATA_O == 8'h00;
    endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
    property p_rd_hold;
        !REG_RD_I |=> $stable(REG_RDATA_O);
    endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
    property p_out_hold;
        OUT_VALID_O && !OUT_READY_I |=> OUT_VALID_O
        && $stable({OUT_PORT_O, OUT_CHANNEL_O, OUT_TYPE_O});
    endproperty
    a_out_hold: assert property (p_out_hold) else $error("header dropped");
    property p_out_lat;
        PKT_VALID_I && PKT_READY_O && !OUT_VALID_O |-> ##[1:4] OUT_VALID_O;
    endproperty
    a_out_lat: assert property (p_out_lat) else $error("header late");
    property p_rdy_fall;
        $fell(PKT_READY_O) |-> $past(PKT_VALID_I);
    endproperty
    a_rdy_fall: assert property (p_rdy_fall) else $error("ready fell alone");
    property p_rdy_back;
        !PKT_READY_O && OUT_VALID_O && OUT_READY_I |-> ##[1:3] PKT_READY_O;
    endproperty
    a_rdy_back: assert property (p_rdy_back) else $error("ready stuck low");
    property p_rdy_stay;
        PKT_READY_O && !PKT_VALID_I |=> PKT_READY_O;
    endproperty
    a_rdy_stay: assert property (p_rdy_stay) else $error("ready fell idle");
endmodule
bind rxmap_top rxmap_sva u_sva (.CLK_I(CLK_I), .RESETN_I(RESETN_I), .PORT_SEL_I(PORT_SEL_I),
    .REG_WR_I(REG_WR_I), .REG_RD_I(REG_RD_I), .REG_ADDR_I(REG_ADDR_I),
    .REG_WDATA_I(REG_WDATA_I), .REG_RDATA_O(REG_RDATA_O), .PKT_VALID_I(PKT_VALID_I),
    .PKT_READY_O(PKT_READY_O), .OUT_VALID_O(OUT_VALID_O), .OUT_READY_I(OUT_READY_I),
    .OUT_PORT_O(OUT_PORT_O), .OUT_CHANNEL_O(OUT_CHANNEL_O), .OUT_TYPE_O(OUT_TYPE_O));
`default_nettype wire

// >>> sim/rxmap_top_bench.sv
// self-checking bench for the channel map and line count block
// assumes rxmap_top, rxmap_sink and the bound checker
`timescale 1ns/10ps
`default_nettype none
module rxmap_top_bench;
    logic clk = 0, rstn = 0, wrs = 0, rds = 0, pv = 0, stall = 1, t;
    logic [1:0] sel = 0, pp = 0, pc = 0;
    logic [7:0] addr = 0, wd = 0, mode = 8'hE4; // ports 0..3: csi, raw12 lf, raw12 hf, raw10
    logic [5:0] pt = 0;
    logic [3:0] irq = 0, fs = 0, le = 0, fe = 0;
    logic [31:0] lf = 98140, x;
    logic [15:0] q [$];
    wire [7:0] rdat;
    wire [1:0] op, oc;
    wire [5:0] ot;
    wire prdy, ov, ordy;
    integer num_errors = 0, checked = 0, cyc = 0, saw_full = 0;
    integer r10 [4], r12 [4], rm [4], cnt [4], lat [4], frz [4];
    rxmap_top dut (.CLK_I(clk), .RESETN_I(rstn), .PORT_SEL_I(sel), .REG_WR_I(wrs),
        .REG_RD_I(rds), .REG_ADDR_I(addr), .REG_WDATA_I(wd), .REG_RDATA_O(rdat),
        .LINES_CHANGED_IRQ_ENABLE_I(irq), .PORT_INPUT_MODE_I(mode), .FRAME_START_I(fs),
        .LINE_END_I(le), .FRAME_END_I(fe), .PKT_VALID_I(pv), .PKT_READY_O(prdy),
        .PKT_PORT_I(pp), .PKT_CHANNEL_I(pc), .PKT_TYPE_I(pt), .OUT_VALID_O(ov),
        .OUT_READY_I(ordy), .OUT_PORT_O(op), .OUT_CHANNEL_O(oc), .OUT_TYPE_O(ot));
    rxmap_sink sink (.clk_i(clk), .resetn_i(rstn), .stall_i(stall), .ready_o(ordy));
    initial forever #5 clk = ~clk;
    function automatic logic [31:0] rnd();
        lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
        return lf;
    endfunction
    function automatic logic [15:0] hdr(input logic [9:0] h);
        integer p, ch, ty;
        p = h[9:8];
        case ((mode >> (2 * p)) & 3)
            0: begin ch = rm[p] >> (2 * h[7:6]); ty = h[5:0]; end
            3: begin ch = r10[p] >> 6; ty = r10[p]; end
            default: begin ch = r12[p] >> 6; ty = r12[p]; end
        endcase
        return {6'h0, h[9:8], ch[1:0], ty[5:0]};
    endfunction
    task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
        checked++;
        if (s !== e) begin
            num_errors++;
            $display("unexpected %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic wrt(input integer p, input logic [7:0] a, input logic [7:0] d);
        {sel, wrs, addr, wd} <= {p[1:0], 1'b1, a, d};
        @(posedge clk);
        wrs <= 0;
        if (a == 8'h70) r10[p] = d;
        if (a == 8'h71) r12[p] = d;
        if (a == 8'h72) rm[p] = d;
    endtask
    task automatic rd(input integer p, input logic [7:0] a);
        integer e;
        {sel, rds, addr} <= {p[1:0], 1'b1, a};
        @(posedge clk);
        rds <= 0;
        e = a == 8'h70 ? r10[p] : a == 8'h71 ? r12[p] : a == 8'h72 ? rm[p] : 0;
        if (a == 8'h73) e = cnt[p] >> 8;
        if (a == 8'h73) lat[p] = cnt[p] & 255;
        if (a == 8'h74) e = lat[p];
        if (a inside {8'h73, 8'h74}) frz[p] = 0;
        @(negedge clk);
        chk("read data", rdat, e[15:0]);
        @(posedge clk);
    endtask
    task automatic frame(input integer p, input integer n);
        fs <= 4'h1 << p;
        @(posedge clk);
        fs <= 0;
        le <= 4'h1 << p;
        repeat (n) @(posedge clk);
        {le, fe} <= {4'h0, 4'h1 << p};
        @(posedge clk);
        fe <= 0;
        @(posedge clk);
        if (frz[p] == 0) cnt[p] = n;
        if (frz[p] == 0) frz[p] = irq[p];
    endtask
    task automatic rall();
        for (int p = 0; p < 4; p++) for (int a = 'h6F; a < 'h76; a++) rd(p, a);
    endtask
    always @(posedge clk) begin
        cyc++;
        if (rstn && ov && ordy) chk("mapped header", {6'h0, op, oc, ot}, q.pop_front());
        if (cyc == 20000) num_errors++;
        if (cyc == 20000) close_out();
    end
    initial begin
        for (int p = 0; p < 4; p++) begin
            {r10[p], r12[p], rm[p]} = {p * 64 + 'h2B, p * 64 + 'h2C, 32'hE4};
            {cnt[p], lat[p], frz[p]} = 0;
        end
        repeat (8) @(posedge clk);
        rstn <= 1;
        @(posedge clk);
        rall();
        for (int p = 0; p < 4; p++) for (int a = 'h70; a < 'h74; a++) begin
            wrt(p, a, rnd());
            rd(p, a);
        end
        rall();
        $display("test registers done");
        irq <= 4'h4;
        frame(1, 300);
        rd(1, 'h73);
        frame(1, 2);
        for (int p = 1; p < 3; p++) begin
            rd(p, 'h74);
            rd(p, 'h73);
            rd(p, 'h74);
            frame(2, 5 + 2 * p);
        end
        frame(2, 3);
        rall();
        $display("test line count done");
        for (int i = 0; i < 48; i++) begin
            x = rnd();
            {pp, pc, pt, pv} <= {x[9:0], 1'b1};
            q.push_back(hdr(x[9:0]));
            do begin
                @(negedge clk);
                t = prdy;
                if (!prdy && saw_full == 0) chk("fifo depth", i, 9);
                if (!prdy) saw_full = 1;
                @(posedge clk);
                stall <= saw_full == 0 || rnd() % 3 == 0;
            end while (!t);
        end
        pv <= 1'b0;
        @(posedge clk);
        stall <= 1'b0;
        for (int k = 0; k < 100 && q.size() > 0; k++) @(posedge clk);
        chk("headers left", q.size(), 0);
        chk("fifo refused", saw_full, 1);
        $display("test packets done");
        close_out();
    end
endmodule
`default_nettype wire
